//--- rtl/ufa_pkg.sv
// Package for the USB function address and power control block
package ufa_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_DEV_ADDR = 8'h00;
   localparam logic [7:0] ADDR_POWER = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_EP_INDEX = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // ------------------------------------------------------------
   // Power register fields
   // ------------------------------------------------------------
   localparam int PWR_SUSP_EN = 0;
   localparam int PWR_SUSP_MODE = 1;
   localparam int PWR_RESUME = 2;
   localparam int PWR_LINK_RST = 3;
   localparam int PWR_INHIBIT = 4;
   localparam int PWR_ISO_SYNC = 7;
   localparam int ADDR_PENDING = 7;
   // ------------------------------------------------------------
   // Interrupt fields
   // ------------------------------------------------------------
   localparam int IRQ_SUSPEND = 0;
   localparam int IRQ_WAKE = 1;
   localparam int IRQ_RESET = 2;
   localparam int IRQ_W = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_ON_BUS_RST = 3'h6;
   // ------------------------------------------------------------
   // Reset values and timing
   // ------------------------------------------------------------
   localparam logic [7:0] DEV_ADDR_RST = 8'h00;
   localparam logic [3:0] EP_INDEX_RST = 4'h0;
   localparam int LINK_RST_NS = 100;
   localparam int CLK_PERIOD_NS = 10;
   localparam int LINK_RST_CYC = (LINK_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // Bus-side events and token, one cycle each
   typedef struct packed {
      logic bus_reset;
      logic suspend;
      logic resume;
      logic sof;
      logic token_valid;
      logic token_in;
      logic [6:0] token_addr;
      logic xfer_done;
   } ufa_link_ev_t;

   // Answer to a token
   typedef struct packed {
      logic accept;
      logic send_zlp;
   } ufa_tok_ans_t;
endpackage

//--- rtl/ufa_axil_slave.sv
// AXI4-Lite slave front end with single-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module ufa_axil_slave import ufa_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_wr_stb,
   output logic [7:0] o_wr_addr,
   output logic [7:0] o_wr_data,
   output logic o_rd_stb,
   output logic [7:0] o_rd_addr,
   input wire logic [31:0] i_rd_data,
   input wire logic i_rd_hit,
   input wire logic i_wr_hit
);
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic rd_wait_reg;
   logic [3:0] wstrb_reg;

   assign o_awready = ~aw_held_reg & ~o_bvalid;
   assign o_wready = ~w_held_reg & ~o_bvalid;
   assign o_arready = ~rd_wait_reg & ~o_rvalid;

   // ------------------------------------------------------------
   // Write path
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         o_wr_stb <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= AXI_OKAY;
      end else begin
         o_wr_stb <= 1'b0;
         if (i_awvalid && o_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= i_wdata;
         end
         if (aw_held_reg && w_held_reg && !o_bvalid) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            o_wr_stb <= i_wr_hit && wstrb_reg[0];
            o_bvalid <= 1'b1;
            o_bresp <= i_wr_hit ? AXI_OKAY : AXI_SLVERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end
   assign o_wr_addr = awaddr_reg;
   // Byte lane zero carries every register
   assign o_wr_data = wdata_reg[7:0];

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         wstrb_reg <= 4'h0;
      end else if (i_wvalid && o_wready) begin
         wstrb_reg <= i_wstrb;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         rd_wait_reg <= 1'b0;
         o_rd_addr <= 8'h00;
         o_rd_stb <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= AXI_OKAY;
      end else begin
         o_rd_stb <= 1'b0;
         if (i_arvalid && o_arready) begin
            rd_wait_reg <= 1'b1;
            o_rd_addr <= i_araddr;
         end
         if (rd_wait_reg) begin
            rd_wait_reg <= 1'b0;
            o_rd_stb <= i_rd_hit;
            o_rvalid <= 1'b1;
            o_rdata <= i_rd_hit ? i_rd_data : 32'h0000_0000;
            o_rresp <= i_rd_hit ? AXI_OKAY : AXI_SLVERR;
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/ufa_rst_gen.sv
// Stretches the software-forced link reset to a fixed pulse
`timescale 1ns/1ps
`default_nettype none
module ufa_rst_gen import ufa_pkg::*; #(
   parameter int CYC = LINK_RST_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_trigger,
   output logic o_link_rst
);
   logic [7:0] cnt_reg;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         cnt_reg <= 8'h00;
         o_link_rst <= 1'b0;
      end else if (i_trigger) begin
         cnt_reg <= 8'(CYC);
         o_link_rst <= 1'b1;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
         o_link_rst <= (cnt_reg != 8'h01);
      end else begin
         o_link_rst <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- rtl/ufa_top.sv
// USB function address, power control and interrupt logic
`timescale 1ns/1ps
`default_nettype none
module ufa_top import ufa_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire ufa_link_ev_t i_link_ev,
   input wire logic i_iso_load,
   output ufa_tok_ans_t o_tok_ans,
   output logic o_iso_release,
   output logic o_fifo_flush,
   output logic o_csr_clear,
   output logic o_resume_drive,
   output logic o_osc_wake,
   output logic o_suspended,
   output logic o_link_reset,
   output logic o_irq
);
   logic wr_stb;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_hit;
   logic wr_hit;
   logic soft_rst;
   logic link_rst;
   logic urst_n;
   logic [6:0] addr_eff_reg;
   logic [6:0] addr_new_reg;
   logic pending_reg;
   logic susp_en_reg;
   logic susp_mode_reg;
   logic resume_reg;
   logic busrst_seen_reg;
   logic inhibit_reg;
   logic iso_sync_reg;
   logic iso_held_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [3:0] ep_index_reg;
   logic ev_bus_rst;
   logic ev_susp;
   logic ev_wake;
   logic [IRQ_W-1:0] irq_clr;

   function automatic logic is_reg(input logic [7:0] a);
      is_reg = (a == ADDR_DEV_ADDR) ||
               (a == ADDR_POWER) ||
               (a == ADDR_IRQ_STAT) ||
               (a == ADDR_IRQ_MASK) ||
               (a == ADDR_EP_INDEX) ||
               (a == ADDR_STATUS);
   endfunction

   function automatic logic wr_to(input logic [7:0] a);
      wr_to = wr_stb && (wr_addr == a);
   endfunction

   // ------------------------------------------------------------
   // Bus slave and reset pulse
   // ------------------------------------------------------------
   assign rd_hit = is_reg(rd_addr);
   assign wr_hit = is_reg(wr_addr);

   ufa_axil_slave u_bus (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready),
      .o_wr_stb(wr_stb),
      .o_wr_addr(wr_addr),
      .o_wr_data(wr_data),
      .o_rd_stb(),
      .o_rd_addr(rd_addr),
      .i_rd_data(rd_data),
      .i_rd_hit(rd_hit),
      .i_wr_hit(wr_hit)
   );

   assign soft_rst = wr_to(ADDR_POWER) && wr_data[PWR_LINK_RST];

   ufa_rst_gen #(
      .CYC(LINK_RST_CYC)
   ) u_rst (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_trigger(soft_rst),
      .o_link_rst(link_rst)
   );

   // Function-wide reset: power-on or forced link reset
   assign urst_n = i_rstn & ~link_rst & ~soft_rst;

   // ------------------------------------------------------------
   // Bus events, ignored while inhibited
   // ------------------------------------------------------------
   assign ev_bus_rst = i_link_ev.bus_reset && !inhibit_reg;
   assign ev_susp = i_link_ev.suspend && susp_en_reg &&
      !inhibit_reg && !susp_mode_reg;
   assign ev_wake = (i_link_ev.resume && !inhibit_reg) ||
      (wr_to(ADDR_POWER) && wr_data[PWR_RESUME]);
   assign irq_clr = wr_to(ADDR_IRQ_STAT) ? wr_data[IRQ_W-1:0] : '0;

   // ------------------------------------------------------------
   // Function address
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!urst_n) begin
         addr_eff_reg <= DEV_ADDR_RST[6:0];
         addr_new_reg <= DEV_ADDR_RST[6:0];
         pending_reg <= 1'b0;
      end else if (ev_bus_rst) begin
         addr_eff_reg <= DEV_ADDR_RST[6:0];
         addr_new_reg <= DEV_ADDR_RST[6:0];
         pending_reg <= 1'b0;
      end else if (wr_to(ADDR_DEV_ADDR)) begin
         addr_new_reg <= wr_data[6:0];
         pending_reg <= 1'b1;
      end else if (pending_reg && i_link_ev.xfer_done) begin
         addr_eff_reg <= addr_new_reg;
         pending_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Power control
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!urst_n) begin
         susp_en_reg <= 1'b0;
         resume_reg <= 1'b0;
         inhibit_reg <= 1'b1;
         iso_sync_reg <= 1'b0;
      end else if (wr_to(ADDR_POWER)) begin
         susp_en_reg <= wr_data[PWR_SUSP_EN];
         resume_reg <= wr_data[PWR_RESUME];
         inhibit_reg <= inhibit_reg & wr_data[PWR_INHIBIT];
         iso_sync_reg <= wr_data[PWR_ISO_SYNC];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!urst_n) begin
         susp_mode_reg <= 1'b0;
      end else if (ev_wake || ev_bus_rst) begin
         susp_mode_reg <= 1'b0;
      end else if (ev_susp) begin
         susp_mode_reg <= 1'b1;
      end
   end

   // Bus reset status, held while the bus shows reset
   always_ff @(posedge i_ref_clk) begin
      if (!urst_n) begin
         busrst_seen_reg <= 1'b0;
      end else if (ev_bus_rst) begin
         busrst_seen_reg <= 1'b1;
      end else if (!i_link_ev.bus_reset) begin
         busrst_seen_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Endpoint index and side effects of bus reset
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!urst_n) begin
         ep_index_reg <= EP_INDEX_RST;
         o_fifo_flush <= 1'b0;
         o_csr_clear <= 1'b0;
      end else begin
         o_fifo_flush <= ev_bus_rst;
         o_csr_clear <= ev_bus_rst;
         if (ev_bus_rst) begin
            ep_index_reg <= EP_INDEX_RST;
         end else if (wr_to(ADDR_EP_INDEX)) begin
            ep_index_reg <= wr_data[3:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Isochronous frame synchronisation
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!urst_n) begin
         iso_held_reg <= 1'b0;
         o_iso_release <= 1'b0;
      end else begin
         o_iso_release <= 1'b0;
         if (i_link_ev.sof && !inhibit_reg) begin
            iso_held_reg <= i_iso_load && iso_sync_reg;
            o_iso_release <= iso_held_reg || (i_iso_load && !iso_sync_reg);
         end else if (i_iso_load) begin
            iso_held_reg <= iso_sync_reg;
            o_iso_release <= !iso_sync_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // Token filter
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!urst_n) begin
         o_tok_ans <= '0;
      end else begin
         o_tok_ans.accept <= i_link_ev.token_valid && !inhibit_reg &&
                             (i_link_ev.token_addr == addr_eff_reg);
         o_tok_ans.send_zlp <= i_link_ev.token_valid && !inhibit_reg && i_link_ev.token_in &&
                               (i_link_ev.token_addr == addr_eff_reg) &&
                               iso_sync_reg && iso_held_reg;
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!urst_n) begin
         irq_mask_reg <= IRQ_MASK_RST;
         irq_stat_reg <= '0;
      end else begin
         if (ev_bus_rst) begin
            irq_mask_reg <= irq_mask_reg | IRQ_MASK_ON_BUS_RST;
         end else if (wr_to(ADDR_IRQ_MASK)) begin
            irq_mask_reg <= wr_data[IRQ_W-1:0];
         end
         if (ev_bus_rst) begin
            irq_stat_reg <= '0;
            irq_stat_reg[IRQ_RESET] <= 1'b1;
         end else begin
            irq_stat_reg[IRQ_SUSPEND] <= ev_susp |
               (irq_stat_reg[IRQ_SUSPEND] & ~irq_clr[IRQ_SUSPEND]);
            irq_stat_reg[IRQ_WAKE] <= (i_link_ev.resume && !inhibit_reg) |
               (irq_stat_reg[IRQ_WAKE] & ~irq_clr[IRQ_WAKE]);
            irq_stat_reg[IRQ_RESET] <= irq_stat_reg[IRQ_RESET] &
               ~irq_clr[IRQ_RESET];
         end
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      if (rd_addr == ADDR_DEV_ADDR) begin
         rd_data[7:0] = {pending_reg, addr_new_reg};
      end else if (rd_addr == ADDR_POWER) begin
         rd_data[PWR_SUSP_EN] = susp_en_reg;
         rd_data[PWR_SUSP_MODE] = susp_mode_reg;
         rd_data[PWR_RESUME] = resume_reg;
         rd_data[PWR_LINK_RST] = busrst_seen_reg;
         rd_data[PWR_INHIBIT] = inhibit_reg;
         rd_data[PWR_ISO_SYNC] = iso_sync_reg;
      end else if (rd_addr == ADDR_IRQ_STAT) begin
         rd_data[IRQ_W-1:0] = irq_stat_reg;
      end else if (rd_addr == ADDR_IRQ_MASK) begin
         rd_data[IRQ_W-1:0] = irq_mask_reg;
      end else if (rd_addr == ADDR_EP_INDEX) begin
         rd_data[3:0] = ep_index_reg;
      end else if (rd_addr == ADDR_STATUS) begin
         rd_data[6:0] = addr_eff_reg;
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_irq <= 1'b0;
         o_resume_drive <= 1'b0;
         o_osc_wake <= 1'b0;
         o_suspended <= 1'b0;
         o_link_reset <= 1'b0;
      end else begin
         o_irq <= |(irq_stat_reg & irq_mask_reg);
         o_resume_drive <= resume_reg;
         o_osc_wake <= susp_mode_reg && (ev_wake || ev_bus_rst || !urst_n);
         o_suspended <= susp_mode_reg;
         o_link_reset <= !urst_n;
      end
   end
endmodule
`default_nettype wire

//--- dv/ufa_top_sva.sv
// Port-level checker for the USB function address and power block
`timescale 1ns/1ps
`default_nettype none
module ufa_top_sva import ufa_pkg::*; (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic [31:0] o_rdata,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [1:0] o_bresp,
   input wire ufa_link_ev_t i_link_ev,
   input wire ufa_tok_ans_t o_tok_ans,
   input wire logic o_fifo_flush,
   input wire logic o_csr_clear,
   input wire logic o_suspended,
   input wire logic o_osc_wake,
   input wire logic o_link_reset
);
   // ------------------------------------------------------------
   // Clocking
   // ------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rstn);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_read_two_cycles: assert property (i_arvalid && o_arready |-> ##2 o_rvalid)
      else $error("read data late");
   a_rdata_held: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped before taken");
   a_bresp_held: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped before taken");
   a_zlp_needs_in: assert property (o_tok_ans.send_zlp |->
      $past(i_link_ev.token_valid && i_link_ev.token_in)) else $error("empty packet without IN token");
   a_accept_after_token: assert property (o_tok_ans.accept |-> $past(i_link_ev.token_valid))
      else $error("token accepted without token");
   a_flush_after_reset: assert property (o_fifo_flush |-> $past(i_link_ev.bus_reset))
      else $error("flush without bus reset");
   a_csr_with_flush: assert property (o_csr_clear == o_fifo_flush)
      else $error("status clear apart from flush");
   a_suspend_cause: assert property ($rose(o_suspended) |-> $past(i_link_ev.suspend, 2))
      else $error("suspend entered without suspend signalling");
   a_suspend_exit: assert property (o_suspended && (i_link_ev.resume || i_link_ev.bus_reset)
      |-> ##2 !o_suspended) else $error("suspend kept after resume or bus reset");
   a_osc_wake: assert property (o_suspended && i_link_ev.resume |-> ##[1:2] o_osc_wake)
      else $error("oscillator not woken");
   a_link_rst_hold: assert property ($rose(o_link_reset) |-> o_link_reset [*8])
      else $error("function reset too short");
   a_link_rst_ends: assert property ($rose(o_link_reset) |-> ##[9:14] !o_link_reset)
      else $error("function reset too long");
   c_suspend: cover property ($rose(o_suspended));
   c_zlp: cover property (o_tok_ans.send_zlp);
   c_flush: cover property (o_fifo_flush);
   c_link_rst: cover property ($rose(o_link_reset));
endmodule
bind ufa_top ufa_top_sva i_ufa_top_sva (.i_ref_clk, .i_rstn, .i_arvalid, .o_arready, .o_rvalid, .i_rready, .o_rdata,
   .o_bvalid, .i_bready, .o_bresp, .i_link_ev, .o_tok_ans, .o_fifo_flush, .o_csr_clear, .o_suspended, .o_osc_wake,
   .o_link_reset);
`default_nettype wire

//--- dv/ufa_host_model.sv
// USB host model driving bus events and tokens
`timescale 1ns/1ps
`default_nettype none
module ufa_host_model import ufa_pkg::*; (
   input wire logic i_ref_clk,
   output var ufa_link_ev_t o_link_ev
);
   initial begin
      o_link_ev = '0;
   end
   // One-cycle bus event
   task automatic pulse(input ufa_link_ev_t ev);
      @(posedge i_ref_clk);
      o_link_ev <= ev;
      @(posedge i_ref_clk);
      o_link_ev <= '0;
   endtask
   task automatic token(input logic [6:0] addr, input logic is_in);
      ufa_link_ev_t ev;
      ev = '0;
      ev.token_valid = 1'b1;
      ev.token_in = is_in;
      ev.token_addr = addr;
      pulse(ev);
   endtask
endmodule
`default_nettype wire

//--- dv/usb_function_addr_power_ctl_tb_top.sv
// Testbench for the USB function address and power block
`timescale 1ns/1ps
`default_nettype none
module usb_function_addr_power_ctl_tb_top import ufa_pkg::*;;
   localparam ufa_link_ev_t EV_SUSP = '{suspend: 1'b1, default: '0};
   localparam ufa_link_ev_t EV_RES = '{resume: 1'b1, default: '0};
   localparam ufa_link_ev_t EV_BRST = '{bus_reset: 1'b1, default: '0};
   localparam ufa_link_ev_t EV_SOF = '{sof: 1'b1, default: '0};
   localparam ufa_link_ev_t EV_DONE = '{xfer_done: 1'b1, default: '0};
   logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, iso_load;
   logic awready, wready, bvalid, arready, rvalid, flush, csr_clr, res_drive, osc_wake, susp, link_rst, irq, iso_rel;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   ufa_link_ev_t link_ev;
   ufa_tok_ans_t tok_ans;
   int n_errors = 0;
   int samples_checked = 0;
   ufa_top i_ufa_top (.i_ref_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
      .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_link_ev(link_ev), .i_iso_load(iso_load),
      .o_tok_ans(tok_ans), .o_iso_release(iso_rel), .o_fifo_flush(flush), .o_csr_clear(csr_clr),
      .o_resume_drive(res_drive), .o_osc_wake(osc_wake), .o_suspended(susp), .o_link_reset(link_rst), .o_irq(irq));
   ufa_host_model i_ufa_host_model (.i_ref_clk(clk), .o_link_ev(link_ev));
   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = AXI_OKAY);
      logic aw_t, w_t, b_t;
      logic [1:0] br;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_t = 1'b0;
      for (int k = 0; k < 40 && !b_t; k++) begin
         @(negedge clk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bvalid;
         br = bresp;
         @(posedge clk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (b_t) bready <= 1'b0;
      end
      chk(34'(br), 34'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = AXI_OKAY);
      logic ar_t, r_t;
      logic [33:0] got;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_t = 1'b0;
      for (int k = 0; k < 40 && !r_t; k++) begin
         @(negedge clk);
         ar_t = arvalid && arready;
         r_t = rvalid;
         got = {rresp, rdata};
         @(posedge clk);
         if (ar_t) arvalid <= 1'b0;
         if (r_t) rready <= 1'b0;
      end
      chk(got, {er, exp});
   endtask
   task automatic tok(input logic [6:0] a, input logic is_in, input logic [1:0] exp);
      i_ufa_host_model.token(a, is_in);
      @(negedge clk);
      chk({32'h00000000, tok_ans}, {32'h00000000, exp});
   endtask
   task automatic ev(input ufa_link_ev_t e);
      i_ufa_host_model.pulse(e);
   endtask
   task automatic rel_chk(input logic do_load, input logic exp);
      logic seen;
      seen = 1'b0;
      if (do_load) begin
         @(posedge clk);
         iso_load <= 1'b1;
         @(posedge clk);
         iso_load <= 1'b0;
      end
      repeat (4) begin
         @(negedge clk);
         seen = seen | iso_rel;
      end
      chk(34'(seen), 34'(exp));
   endtask
   task automatic complete_run();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, watchdog and tests
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      complete_run();
   end
   initial begin
      rstn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, iso_load} = '0;
      {awaddr, araddr, wdata} = '0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rd(ADDR_POWER, 32'h10);
      rd(ADDR_DEV_ADDR, 32'h0);
      rd(ADDR_IRQ_MASK, 32'h0);
      rd(8'h18, 32'h0, AXI_SLVERR);
      wr(8'h18, 8'hFF, AXI_SLVERR);
      tok(7'h00, 1'b0, 2'b00);
      wr(ADDR_POWER, 8'h08);
      repeat (LINK_RST_CYC + 2) @(posedge clk);
      wr(ADDR_POWER, 8'h00);
      wr(ADDR_POWER, 8'h10);
      rd(ADDR_POWER, 32'h00);
      tok(7'h00, 1'b0, 2'b10);
      wr(ADDR_DEV_ADDR, 8'h05);
      rd(ADDR_DEV_ADDR, 32'h85);
      tok(7'h05, 1'b0, 2'b00);
      tok(7'h00, 1'b0, 2'b10);
      ev(EV_DONE);
      rd(ADDR_DEV_ADDR, 32'h05);
      rd(ADDR_STATUS, 32'h05);
      tok(7'h05, 1'b0, 2'b10);
      // Suspend, interrupt and resume
      wr(ADDR_IRQ_MASK, 8'h07);
      wr(ADDR_POWER, 8'h01);
      ev(EV_SUSP);
      repeat (2) @(negedge clk);
      chk(34'(susp), 34'h1);
      rd(ADDR_POWER, 32'h03);
      rd(ADDR_IRQ_STAT, 32'h01);
      chk(34'(irq), 34'h1);
      wr(ADDR_IRQ_STAT, 8'h01);
      rd(ADDR_IRQ_STAT, 32'h00);
      chk(34'(irq), 34'h0);
      ev(EV_RES);
      @(negedge clk);
      chk(34'(osc_wake), 34'h1);
      @(negedge clk);
      chk(34'(susp), 34'h0);
      rd(ADDR_IRQ_STAT, 32'h02);
      wr(ADDR_IRQ_MASK, 8'h00);
      repeat (2) @(negedge clk);
      chk(34'(irq), 34'h0);
      wr(ADDR_IRQ_STAT, 8'h02);
      // Remote wakeup
      ev(EV_SUSP);
      wr(ADDR_POWER, 8'h05);
      repeat (2) @(negedge clk);
      chk(34'({res_drive, susp}), 34'h2);
      wr(ADDR_POWER, 8'h01);
      repeat (2) @(negedge clk);
      chk(34'(res_drive), 34'h0);
      // Frame-synchronised isochronous IN
      wr(ADDR_POWER, 8'h81);
      rel_chk(1'b1, 1'b0);
      tok(7'h05, 1'b1, 2'b11);
      ev(EV_SOF);
      rel_chk(1'b0, 1'b1);
      wr(ADDR_POWER, 8'h01);
      rel_chk(1'b1, 1'b1);
      // Bus reset
      wr(ADDR_IRQ_STAT, 8'h07);
      wr(ADDR_EP_INDEX, 8'h03);
      rd(ADDR_EP_INDEX, 32'h03);
      ev(EV_BRST);
      @(negedge clk);
      chk(34'({flush, csr_clr}), 34'h3);
      rd(ADDR_DEV_ADDR, 32'h00);
      rd(ADDR_STATUS, 32'h00);
      rd(ADDR_EP_INDEX, 32'h00);
      rd(ADDR_IRQ_MASK, 32'h06);
      rd(ADDR_IRQ_STAT, 32'h04);
      chk(34'(irq), 34'h1);
      i_ufa_host_model.o_link_ev <= EV_BRST;
      rd(ADDR_POWER, 32'h09);
      i_ufa_host_model.o_link_ev <= '0;
      // Software-forced function reset
      wr(ADDR_POWER, 8'h08);
      @(negedge clk);
      chk(34'(link_rst), 34'h1);
      repeat (20) @(negedge clk);
      chk(34'(link_rst), 34'h0);
      rd(ADDR_POWER, 32'h10);
      rd(ADDR_IRQ_MASK, 32'h00);
      complete_run();
   end
endmodule
`default_nettype wire
